/* hdl/gdf_pkg.sv */
// package: constants for the gate driver fault / reset-enable control block
package gdf_pkg;

	localparam int unsigned CLK_PERIOD_PS   = 5000;
	// least glitch width that must pass, in ns; rounded up to whole cycles
	localparam int unsigned DEGLITCH_NS     = 40;
	localparam int unsigned DEGLITCH_CYC    = (DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// mute time after a fault latches, in ns (no figure given; plain default)
	localparam int unsigned FAULT_MUTE_NS   = 1000;
	localparam int unsigned FAULT_MUTE_CYC  = (FAULT_MUTE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// least low time of reset_n_enable after the mute time, in ns (plain default)
	localparam int unsigned RESET_FILT_NS   = 500;
	localparam int unsigned RESET_FILT_CYC  = (RESET_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CNT_W           = 16;
	localparam logic        GATE_RST        = 1'b0;
	localparam logic        FLAG_OE_RST     = 1'b0;

	typedef enum logic [2:0]
	{
		GDF_RUN   = 3'b001,
		GDF_MUTE  = 3'b010,
		GDF_ARMED = 3'b100
	} gdf_state_t;

	function automatic logic [CNT_W-1:0] gdf_sat_inc(input logic [CNT_W-1:0] v);
		gdf_sat_inc = (v == {CNT_W{1'b1}}) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
	endfunction : gdf_sat_inc

endpackage : gdf_pkg

/* hdl/gdf_deglitch.sv */
// module: two-flop synchroniser followed by a glitch filter on one pin
`timescale 1ns/1ps
module gdf_deglitch
	import gdf_pkg::*;
#(
	parameter int unsigned FILT_CYC = DEGLITCH_CYC,
	parameter logic        INIT     = 1'b0
)
(
	input  wire logic clock,    // system clock
	input  wire logic rst,      // async reset, active high
	input  wire logic pin_in,   // raw pin level
	output logic      level_out // filtered level
);

	logic            meta_r;
	logic            sync_r;
	logic [CNT_W-1:0] run_r;
	logic [CNT_W-1:0] run_nxt;
	logic            level_r;
	wire             differs;
	wire             accept;

	assign differs = (sync_r != level_r);
	// a new level is taken only once it has stood for the whole filter window
	assign accept  = differs && (run_r >= CNT_W'(FILT_CYC - 1));
	assign run_nxt = differs ? gdf_sat_inc(run_r) : '0;
	assign level_out = level_r;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			meta_r  <= INIT;
			sync_r  <= INIT;
			run_r   <= '0;
			level_r <= INIT;
		end
		else
		begin
			meta_r  <= pin_in;
			sync_r  <= meta_r;
			run_r   <= accept ? '0 : run_nxt;
			level_r <= accept ? sync_r : level_r;
		end
	end

endmodule : gdf_deglitch

/* hdl/gdf_ctrl.sv */
// module: gate driver enable, overcurrent fault latch and reset control
// Functional notes
// - reset_n_enable both gates the output and clears a latched fault.
// - gate is on only while reset_n_enable is high.
// - an undriven reset_n_enable reads low, so the driver stays disabled; gdf_ctrl has no pull-down, the tri0 net in the testbench gives it.
// - overcurrent latches gate output and fault flag low until a valid reset.
// - reset_n_enable is ignored until the fault mute time has passed.
// - automatic arrangement clears a latched fault every switching cycle.
// - gate is low whenever both drive inputs are high.
// - pulses shorter than 40ns on the three inputs are rejected.
// - fault and power-good flags are open-drain, pulling low when asserted.
`timescale 1ns/1ps
module gdf_ctrl
	import gdf_pkg::*;
#(
	parameter int unsigned MUTE_CYC   = FAULT_MUTE_CYC,
	parameter int unsigned FILT_CYC   = RESET_FILT_CYC,
	parameter int unsigned GLITCH_CYC = DEGLITCH_CYC
)
(
	input  wire logic clock,              // 200 MHz system clock
	input  wire logic rst,                // async reset, active high
	input  wire logic drive_in_noninv,    // non-inverting drive input pin
	input  wire logic drive_in_inv,       // inverting drive input pin
	input  wire logic reset_n_enable,     // low: disable / reset, high: enable
	input  wire logic overcurrent_sense,  // overcurrent comparator pin
	input  wire logic supply_ok,          // output supply above lockout level
	output logic      gate_pull_up,       // turn-on stage drive
	output logic      gate_pull_down,     // turn-off stage drive
	output logic      fault_flag_n_o,     // fault flag pin output level (always 0)
	output logic      fault_flag_n_oe,    // fault flag pulls low when high
	output logic      power_good_flag_o,  // power-good pin output level (always 0)
	output logic      power_good_flag_oe  // power-good pulls low when high
);

	logic       noninv_f;
	logic       inv_f;
	logic       rstn_en_f;
	logic       ovc_meta_r;
	logic       ovc_sync_r;
	logic       sup_meta_r;
	logic       sup_sync_r;
	gdf_state_t state_r;
	gdf_state_t state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic       gate_r;
	logic       gate_nxt;
	logic       fault_oe_r;
	logic       pg_oe_r;

	wire        cmd_on;
	wire        enabled;
	wire        supply_good;
	wire        ovc_hit;
	wire        fault_oe_nxt;
	wire        pg_oe_nxt;
	wire        mute_done;
	wire        filt_done;
	wire        rst_low;

	// a counter that starts at zero has seen n cycles once it reads n-1;
	// a zero count is treated as one cycle so the compare cannot wrap
	function automatic logic cnt_reached(input logic [CNT_W-1:0] v, input int unsigned n);
		logic [CNT_W-1:0] lim;
		lim = (n == 0) ? '0 : CNT_W'(n - 1);
		cnt_reached = (v >= lim);
	endfunction : cnt_reached

	// filtered inputs; INIT 0 keeps an unknown enable in the disabled state
	gdf_deglitch #(.FILT_CYC(GLITCH_CYC), .INIT(1'b0)) u_dg_noninv
	(
		.clock     (clock),
		.rst       (rst),
		.pin_in    (drive_in_noninv),
		.level_out (noninv_f)
	);
	gdf_deglitch #(.FILT_CYC(GLITCH_CYC), .INIT(1'b1)) u_dg_inv
	(
		.clock     (clock),
		.rst       (rst),
		.pin_in    (drive_in_inv),
		.level_out (inv_f)
	);
	gdf_deglitch #(.FILT_CYC(GLITCH_CYC), .INIT(1'b0)) u_dg_rstn
	(
		.clock     (clock),
		.rst       (rst),
		.pin_in    (reset_n_enable),
		.level_out (rstn_en_f)
	);

	// interlock: both inputs high forces the gate off
	assign cmd_on    = noninv_f & ~inv_f;
	assign enabled   = rstn_en_f;
	assign rst_low   = ~rstn_en_f;
	assign supply_good = sup_sync_r;
	// the comparator is only meaningful while the switch conducts
	assign ovc_hit   = ovc_sync_r & gate_r;
	assign mute_done = cnt_reached(cnt_r, MUTE_CYC);
	assign filt_done = cnt_reached(cnt_r, FILT_CYC);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = gdf_sat_inc(cnt_r);
		gate_nxt  = 1'b0;
		case (state_r)
			GDF_RUN:
			begin
				cnt_nxt  = '0;
				// a fault wins over any command seen in the same cycle
				if (ovc_hit)
				begin
					state_nxt = GDF_MUTE;
				end
				else
				begin
					gate_nxt = supply_good & enabled & cmd_on;
				end
			end
			GDF_MUTE:
			begin
				// reset_n_enable is not looked at here at all
				if (mute_done)
				begin
					state_nxt = GDF_ARMED;
					cnt_nxt   = '0;
				end
			end
			GDF_ARMED:
			begin
				// low time counts only after the mute window; a high restarts it
				if (!rst_low)
				begin
					cnt_nxt = '0;
				end
				else if (filt_done)
				begin
					state_nxt = GDF_RUN;
					cnt_nxt   = '0;
				end
			end
			default:
			begin
				state_nxt = GDF_MUTE;
				cnt_nxt   = '0;
			end
		endcase
	end

	// the fault flag follows the state about to be entered, so it rises
	// on the same edge that forces the gate off and never lags it
	assign fault_oe_nxt       = (state_nxt != GDF_RUN);
	// power-good pulls low as long as the synchronised supply is not good
	assign pg_oe_nxt          = ~supply_good;

	// flag pins: drive low (oe high) while asserted, released otherwise
	assign fault_flag_n_o     = 1'b0;
	assign fault_flag_n_oe    = fault_oe_r;
	assign power_good_flag_o  = 1'b0;
	assign power_good_flag_oe = pg_oe_r;
	assign gate_pull_up       = gate_r;
	assign gate_pull_down     = ~gate_r;

	// pin synchronisers; only the second stage is read by the logic
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ovc_meta_r <= 1'b0;
			ovc_sync_r <= 1'b0;
			sup_meta_r <= 1'b0;
			sup_sync_r <= 1'b0;
		end
		else
		begin
			ovc_meta_r <= overcurrent_sense;
			ovc_sync_r <= ovc_meta_r;
			sup_meta_r <= supply_ok;
			sup_sync_r <= sup_meta_r;
		end
	end

	// fault state and the shared mute / filter counter
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_r <= GDF_RUN;
			cnt_r   <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// registered outputs; power-good starts asserted until the supply is seen
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			gate_r     <= GATE_RST;
			fault_oe_r <= FLAG_OE_RST;
			pg_oe_r    <= 1'b1;
		end
		else
		begin
			gate_r     <= gate_nxt;
			fault_oe_r <= fault_oe_nxt;
			pg_oe_r    <= pg_oe_nxt;
		end
	end

endmodule : gdf_ctrl

/* verification/gdf_ctrl_sva.sv */
// checker: port assertions for gdf_ctrl
`timescale 1ns/1ps
module gdf_ctrl_sva
	import gdf_pkg::*;
#(
	parameter int unsigned MUTE_CYC = FAULT_MUTE_CYC,
	parameter int unsigned FILT_CYC = RESET_FILT_CYC
)
(
	input wire logic clock, // clk
	input wire logic rst, // reset
	input wire logic drive_in_noninv, // pin
	input wire logic drive_in_inv, // pin
	input wire logic reset_n_enable, // pin
	input wire logic overcurrent_sense, // pin
	input wire logic supply_ok, // pin
	input wire logic gate_pull_up, // out
	input wire logic gate_pull_down, // out
	input wire logic fault_flag_n_o, // out
	input wire logic fault_flag_n_oe, // out
	input wire logic power_good_flag_o, // out
	input wire logic power_good_flag_oe // out
);
	// run lengths saturate so long idle stretches cannot wrap
	logic [7:0] lo_r, both_r;
	// wide enough to hold mute plus filter time at the default figures
	logic [15:0] fault_r;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			lo_r <= 8'h00;
			both_r <= 8'h00;
			fault_r <= 16'h0000;
		end
		else
		begin
			lo_r <= reset_n_enable ? 8'h00 : lo_r + {7'h00, lo_r < 8'h20};
			both_r <= (drive_in_noninv && drive_in_inv) ? both_r + {7'h00, both_r < 8'h20} : 8'h00;
			fault_r <= fault_flag_n_oe ? fault_r + {15'h0000, fault_r < 16'hFFF0} : 16'h0000;
		end
	end
	gate_compl_a: assert property (gate_pull_down == !gate_pull_up) else $error("gate stages clash");
	od_level_a: assert property (!fault_flag_n_o && !power_good_flag_o) else $error("flag level high");
	en_off_a: assert property (lo_r > 8'h10 |-> !gate_pull_up) else $error("gate on while disabled");
	interlock_a: assert property (both_r > 8'h10 |-> !gate_pull_up) else $error("gate on, both high");
	gate_cause_a: assert property ($rose(gate_pull_up) |-> $past(reset_n_enable, 5)
		&& $past(drive_in_noninv, 5) && !$past(drive_in_inv, 5)) else $error("gate rose uncommanded");
	latch_off_a: assert property (fault_flag_n_oe |-> !gate_pull_up) else $error("gate on in fault");
	fault_cause_a: assert property ($rose(fault_flag_n_oe) |-> $past(overcurrent_sense, 3)
		&& $past(gate_pull_up)) else $error("fault without cause");
	mute_hold_a: assert property ($fell(fault_flag_n_oe) |-> fault_r >= MUTE_CYC + FILT_CYC)
		else $error("fault cleared early");
	pgood_a: assert property (!$past(supply_ok, 3) && !$past(supply_ok, 4)
		|-> power_good_flag_oe && !gate_pull_up) else $error("supply loss missed");
	cov_fault_c: cover property ($rose(fault_flag_n_oe));
	cov_clear_c: cover property ($fell(fault_flag_n_oe));
	cov_gate_c: cover property ($rose(gate_pull_up));
endmodule : gdf_ctrl_sva
bind gdf_ctrl gdf_ctrl_sva #(.MUTE_CYC(MUTE_CYC), .FILT_CYC(FILT_CYC)) u_gdf_ctrl_sva (.*);

/* verification/gdf_host.sv */
// host model: drives the pwm inputs and reset/enable pin
`timescale 1ns/1ps
module gdf_host
(
	input wire logic [1:0] mode, // 0 manual, 1 auto on noninv, 2 auto on inv
	input wire logic pwm, // pwm command
	input wire logic en, // manual enable level
	input wire logic hiz, // release reset/enable
	input wire logic ni_m, // manual noninv level
	input wire logic inv_m, // manual inv level
	output wire logic ni, // noninv pin
	output wire logic inv, // inv pin
	output tri0 logic rne // reset/enable, pulled down
);
	assign ni = (mode == 2'h1) ? pwm : (mode == 2'h2) ? 1'b1 : ni_m;
	assign inv = (mode == 2'h2) ? !pwm : (mode == 2'h1) ? 1'b0 : inv_m;
	assign rne = (mode == 2'h1) ? ni : (mode == 2'h2) ? !inv : (hiz ? 1'bz : en);
endmodule : gdf_host

/* verification/tb_top.sv */
// testbench: random and corner scenarios for gdf_ctrl
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [1:0] mode = 2'h0;
	logic pwm = 1'b0, en = 1'b0, hiz = 1'b0, ni_m = 1'b0, inv_m = 1'b0;
	logic overcurrent_sense = 1'b0, supply_ok = 1'b1;
	logic gate_pull_up, gate_pull_down, fault_flag_n_o, fault_flag_n_oe, power_good_flag_o, power_good_flag_oe;
	wire drive_in_noninv, drive_in_inv;
	tri0 reset_n_enable;
	tri1 fault_flag_n;
	int error_cnt = 0, n_compared = 0;
	logic [2:0] v;
	assign fault_flag_n = fault_flag_n_oe ? fault_flag_n_o : 1'bz;
	always #2.5 clock = !clock;
	gdf_ctrl #(.MUTE_CYC(4), .FILT_CYC(14)) u_gdf_ctrl (.*);
	gdf_host u_gdf_host (.ni(drive_in_noninv), .inv(drive_in_inv), .rne(reset_n_enable), .*);
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt
	task automatic chk(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask : chk
	task automatic end_of_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic wait_clr;
		int i;
		for (i = 0; i < 80 && fault_flag_n !== 1'b1; i++)
			wt(1);
		chk("clear", 1'b1, fault_flag_n);
		if (fault_flag_n !== 1'b1)
			end_of_test();
	endtask : wait_clr
	function automatic logic gl(input logic [2:0] c);
		gl = c[2] & !c[1] & c[0];
	endfunction : gl
	initial
	begin
		void'($urandom(32'hB6855F97));
		wt(6);
		rst <= 1'b0;
		repeat (24)
		begin
			v = 3'($urandom);
			{ni_m, inv_m, en} <= v;
			wt(16);
			chk("gate", gl(v), gate_pull_up);
			chk("gate_dn", !gl(v), gate_pull_down);
		end
		for (int k = 0; k < 3; k++)
		begin
			{ni_m, inv_m, en} <= 3'b101;
			wt(16);
			{ni_m, inv_m, en} <= 3'b101 ^ (3'b001 << k);
			wt(4);
			{ni_m, inv_m, en} <= 3'b101;
			repeat (16)
			begin
				wt(1);
				chk("glitch", 1'b1, gate_pull_up);
			end
		end
		hiz <= 1'b1;
		wt(16);
		chk("float", 1'b0, gate_pull_up);
		overcurrent_sense <= 1'b1;
		wt(6);
		overcurrent_sense <= 1'b0;
		wt(4);
		chk("ovc_off", 1'b1, fault_flag_n);
		hiz <= 1'b0;
		supply_ok <= 1'b0;
		wt(6);
		chk("pgood", 1'b1, power_good_flag_oe);
		supply_ok <= 1'b1;
		wt(16);
		chk("gate", 1'b1, gate_pull_up);
		chk("pgood_off", 1'b0, power_good_flag_oe);
		overcurrent_sense <= 1'b1;
		wt(5);
		overcurrent_sense <= 1'b0;
		chk("gate", 1'b0, gate_pull_up);
		en <= 1'b0;
		wt(10);
		en <= 1'b1;
		wt(30);
		chk("latch", 1'b0, fault_flag_n);
		en <= 1'b0;
		wait_clr();
		en <= 1'b1;
		wt(16);
		chk("gate", 1'b1, gate_pull_up);
		for (int m = 1; m < 3; m++)
		begin
			mode <= 2'(m);
			for (int p = 0; p < 3; p++)
			begin
				pwm <= 1'b1;
				wt(20);
				chk("gate", 1'b1, gate_pull_up);
				overcurrent_sense <= (p == 0);
				wt(20);
				overcurrent_sense <= 1'b0;
				chk("fault", p != 0, fault_flag_n);
				pwm <= 1'b0;
				wt(40);
			end
		end
		end_of_test();
	end
endmodule : tb_top
